// *** fsb_gate.sv ***
// flash command gating, self-programming control and boot swap mapping
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fsb_gate
   import fsb_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_npor,
   input  wire logic              i_flash_mode_select_pin,
   input  wire logic [REG_AW-1:0] i_addr,
   input  wire logic [REG_DW-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [REG_DW-1:0] o_rdata,
   input  wire logic              i_pg_valid,
   input  wire logic [1:0]        i_pg_cmd,
   input  wire logic [FA_W-1:0]   i_pg_addr,
   input  wire logic [7:0]        i_pg_data,
   output logic                   o_pg_ack,
   output logic                   o_pg_nak,
   output logic                   o_fl_start,
   output logic      [1:0]        o_fl_op,
   output logic      [FA_W-1:0]   o_fl_addr,
   output logic      [7:0]        o_fl_data,
   output logic                   o_fl_abort,
   input  wire logic              i_fl_done,
   input  wire logic [7:0]        i_irq_request_flags_0_low,
   input  wire logic [7:0]        i_irq_request_flags_0_high,
   input  wire logic [7:0]        i_irq_request_flags_1_low,
   input  wire logic [7:0]        i_irq_request_flags_1_high,
   input  wire logic [7:0]        i_irq_mask_flags_0_low,
   input  wire logic [7:0]        i_irq_mask_flags_0_high,
   input  wire logic [7:0]        i_irq_mask_flags_1_low,
   input  wire logic [7:0]        i_irq_mask_flags_1_high,
   input  wire logic              i_cpu_on_subclk,
   input  wire logic              i_internal_osc_stop_flag,
   input  wire logic              i_cpu_stop,
   output logic                   o_hsosc_run,
   output logic                   o_boot_swap,
   input  wire logic [FA_W-1:0]   i_map_addr,
   output logic      [FA_W-1:0]   o_map_addr,
   output logic      [3:0]        o_mode
);
   fsb_nv_if nv ();

   fsb_nvstore u_nvstore (
      .i_clk  (i_clk),
      .i_npor (i_npor),
      .nv     (nv.store)
   );

   // ****************************************************************
   // declarations
   // ****************************************************************
   fsb_mode_t        mode_q;
   fsb_exec_t        ex_q;
   logic             pin_s1_q;
   logic             pin_s2_q;
   logic [1:0]       boot_cnt_q;
   logic [3:0]       act_q;
   logic             swap_act_q;
   logic             src_self_q;
   fsb_op_t          cur_op_q;
   logic [FA_W-1:0]  addr_q;
   logic [7:0]       data_q;
   logic [5:0]       secset_q;
   logic             done_q;
   logic             err_q;
   logic             aborted_q;
   logic [1:0]       self_op_q;
   logic [31:0]      irq_req;
   logic [31:0]      irq_msk;
   logic             irq_pend;
   logic             pg_rej;
   logic             self_rej;
   logic             wr_ctrl;
   logic             wr_cmd;
   logic             pg_take;
   logic             pg_go;
   logic             pg_sec;
   logic             self_go;
   logic             self_sec;
   logic             resume;
   logic             abort_now;
   fsb_op_t          pg_op;
   fsb_op_t          self_op;

   assign pg_op   = fsb_op_t'(i_pg_cmd);
   assign self_op = fsb_op_t'(wr_cmd ? i_wdata[1:0] : self_op_q);

   // ****************************************************************
   // pin synchroniser
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end
      else
      begin
         pin_s1_q <= i_flash_mode_select_pin;
         pin_s2_q <= pin_s1_q;
      end
   end

   // ****************************************************************
   // pending interrupt detection
   // ****************************************************************
   assign irq_req = {i_irq_request_flags_1_high, i_irq_request_flags_1_low,
                     i_irq_request_flags_0_high, i_irq_request_flags_0_low};
   assign irq_msk = {i_irq_mask_flags_1_high, i_irq_mask_flags_1_low,
                     i_irq_mask_flags_0_high, i_irq_mask_flags_0_low};

   logic [IRQ_BYTES-1:0] byte_pend;
   genvar g;
   generate
      for (g = 0; g < IRQ_BYTES; g++)
      begin : g_irq
         // global enable is deliberately not looked at
         assign byte_pend[g] = |(irq_req[8*g +: 8] & ~irq_msk[8*g +: 8]);
      end
   endgenerate
   assign irq_pend = |byte_pend;

   // ****************************************************************
   // command gating
   // ****************************************************************
   always_comb
   begin
      pg_rej = 1'b0;
      case (pg_op)
         OP_CHIP_ERASE:  pg_rej = act_q[SEC_CE] | act_q[SEC_BC0];
         OP_BLOCK_ERASE: pg_rej = act_q[SEC_CE] | act_q[SEC_BE] | act_q[SEC_WR]
                                  | (act_q[SEC_BC0] && i_pg_addr < BC1_BASE);
         OP_WRITE:       pg_rej = act_q[SEC_WR]
                                  | (act_q[SEC_BC0] && i_pg_addr < BC1_BASE);
         default:        pg_rej = 1'b0;
      endcase
   end

   always_comb
   begin
      self_rej = 1'b1;
      case (self_op)
         // no chip erase here, so self-programming cannot lift locks
         OP_CHIP_ERASE:  self_rej = 1'b1;
         OP_BLOCK_ERASE: self_rej = act_q[SEC_BC0] && addr_q < BC1_BASE;
         OP_WRITE:       self_rej = act_q[SEC_BC0] && addr_q < BC1_BASE;
         default:        self_rej = 1'b0;
      endcase
   end

   assign wr_ctrl   = i_wr && i_addr == REG_CTRL;
   assign wr_cmd    = i_wr && i_addr == REG_CMD && mode_q == MD_SELF;
   assign pg_take   = i_pg_valid && mode_q == MD_PROG;
   assign pg_sec    = pg_take && pg_op == OP_SEC_SET;
   assign pg_go     = pg_take && pg_op != OP_SEC_SET && ex_q == EX_IDLE && !pg_rej;
   assign resume    = wr_ctrl && i_wdata[CTRL_RESUME] && aborted_q && mode_q == MD_SELF;
   assign self_sec  = wr_cmd && self_op == OP_SEC_SET;
   assign self_go   = (wr_cmd || resume) && self_op != OP_SEC_SET && ex_q == EX_IDLE
                      && !self_rej;
   assign abort_now = mode_q == MD_SELF && ex_q == EX_BUSY && irq_pend && !i_fl_done;

   // ****************************************************************
   // operating mode
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         mode_q     <= MD_BOOT;
         boot_cnt_q <= 2'h0;
         act_q      <= 4'h0;
         swap_act_q <= 1'b0;
      end
      else
      begin
         case (mode_q)
            MD_BOOT:
            begin
               // wait until the synchronised pin reflects the strap
               boot_cnt_q <= boot_cnt_q + 2'h1;
               if (boot_cnt_q == 2'(BOOT_WAIT))
               begin
                  act_q      <= nv.stored[3:0];
                  swap_act_q <= nv.stored[SEC_SWAP];
                  mode_q     <= pin_s2_q ? MD_PROG : MD_NORMAL;
               end
            end
            MD_NORMAL:
            begin
               // entry refused on subsystem clock or with the pin low
               if (wr_ctrl && i_wdata[CTRL_ENTER] && !i_cpu_on_subclk && pin_s2_q)
               begin
                  act_q  <= nv.stored[3:0];
                  mode_q <= MD_SELF;
               end
            end
            MD_SELF:
            begin
               if ((wr_ctrl && i_wdata[CTRL_EXIT] && ex_q == EX_IDLE) || i_cpu_on_subclk)
               begin
                  mode_q <= MD_NORMAL;
               end
            end
            MD_PROG:    mode_q <= MD_PROG;
            default:    mode_q <= MD_BOOT;
         endcase
      end
   end

   // ****************************************************************
   // flash operation sequencer
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         ex_q       <= EX_IDLE;
         cur_op_q   <= OP_CHIP_ERASE;
         src_self_q <= 1'b0;
         o_fl_start <= 1'b0;
         o_fl_op    <= 2'h0;
         o_fl_addr  <= 16'h0000;
         o_fl_data  <= 8'h00;
         o_fl_abort <= 1'b0;
         o_pg_ack   <= 1'b0;
         o_pg_nak   <= 1'b0;
      end
      else
      begin
         o_fl_start <= 1'b0;
         o_fl_abort <= 1'b0;
         o_pg_ack   <= pg_sec;
         // rejected or busy commands never reach the array
         o_pg_nak   <= pg_take && !pg_sec && !pg_go;
         case (ex_q)
            EX_IDLE:
            begin
               if (pg_go || self_go)
               begin
                  ex_q       <= EX_BUSY;
                  cur_op_q   <= pg_go ? pg_op : self_op;
                  src_self_q <= !pg_go;
                  o_fl_start <= 1'b1;
                  o_fl_op    <= pg_go ? i_pg_cmd : self_op;
                  o_fl_addr  <= pg_go ? i_pg_addr : addr_q;
                  o_fl_data  <= pg_go ? i_pg_data : data_q;
               end
            end
            EX_BUSY:
            begin
               if (i_fl_done)
               begin
                  ex_q     <= EX_IDLE;
                  o_pg_ack <= !src_self_q;
               end
               else if (abort_now)
               begin
                  ex_q       <= EX_IDLE;
                  o_fl_abort <= 1'b1;
               end
            end
            default: ex_q <= EX_IDLE;
         endcase
      end
   end

   // security writes wait for the next entry
   assign nv.set_req  = pg_sec || self_sec;
   assign nv.set_bits = pg_sec ? i_pg_data[SEC_W-1:0] : secset_q[SEC_W-1:0];
   assign nv.swap_clr = (pg_sec && i_pg_data[SEC_SWAP_CLR]) || (self_sec && secset_q[SEC_SWAP_CLR]);
   assign nv.clr_req  = ex_q == EX_BUSY && i_fl_done && !src_self_q
                        && cur_op_q == OP_CHIP_ERASE;

   // ****************************************************************
   // software registers and status
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         addr_q    <= 16'h0000;
         data_q    <= 8'h00;
         secset_q  <= 6'h00;
         self_op_q <= 2'h0;
         done_q    <= 1'b0;
         err_q     <= 1'b0;
         aborted_q <= 1'b0;
      end
      else
      begin
         if (i_wr && i_addr == REG_ADDR)
            addr_q <= i_wdata;
         if (i_wr && i_addr == REG_DATA)
            data_q <= i_wdata[7:0];
         if (i_wr && i_addr == REG_SECSET)
            secset_q <= i_wdata[5:0];
         if (wr_cmd)
         begin
            self_op_q <= i_wdata[1:0];
            done_q    <= self_sec;
            err_q     <= !self_sec && !self_go;
         end
         if (resume)
         begin
            err_q <= !self_go;
         end
         if (self_go)
            aborted_q <= 1'b0;
         // events win over the clears above
         if (ex_q == EX_BUSY && src_self_q && i_fl_done)
            done_q <= 1'b1;
         if (abort_now)
            aborted_q <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_rdata <= 16'h0000;
      end
      else
      begin
         o_rdata <= 16'h0000;
         if (i_rd)
         begin
            case (i_addr)
               REG_ADDR:   o_rdata <= addr_q;
               REG_DATA:   o_rdata <= {8'h00, data_q};
               REG_SECSET: o_rdata <= {10'h000, secset_q};
               REG_STATUS:
               begin
                  o_rdata[ST_MODE_LSB +: 4] <= mode_q;
                  o_rdata[ST_BUSY]          <= ex_q == EX_BUSY;
                  o_rdata[ST_DONE]          <= done_q;
                  o_rdata[ST_ERR]           <= err_q;
                  o_rdata[ST_ABORT]         <= aborted_q;
                  o_rdata[ST_ACT_LSB +: 4]  <= act_q;
                  o_rdata[ST_SWAP]          <= swap_act_q;
               end
               REG_NVSTAT: o_rdata <= {11'h000, nv.stored};
               default:    o_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // ****************************************************************
   // oscillator and boot swap outputs
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_hsosc_run <= 1'b1;
         o_boot_swap <= 1'b0;
         o_map_addr  <= 16'h0000;
         o_mode      <= 4'h0;
      end
      else
      begin
         // forced on while self-programming
         o_hsosc_run <= mode_q == MD_SELF || !(i_internal_osc_stop_flag || i_cpu_stop);
         o_boot_swap <= swap_act_q;
         o_mode      <= mode_q;
         // swapping the two 4 KB clusters is a single address-bit flip
         if (swap_act_q && i_map_addr < BC_END)
            o_map_addr <= i_map_addr ^ BC1_BASE;
         else
            o_map_addr <= i_map_addr;
      end
   end
endmodule : fsb_gate
`default_nettype wire

// *** fsb_pkg.sv ***
// constants and types for the flash security and boot swap block
//
// Summary of operation
// - new security applies from next mode entry
// - chip-erase lock rejects programmer chip and block erase
// - chip-erase lock makes every lock permanent
// - block-erase lock blocks programmer, not self-programming
// - write lock blocks programmer write and block erase
// - boot-cluster-0 lock guards cluster and chip erase
// - boot-cluster-0 lock can never be undone
// - shipped state has all locks clear
// - programmer chip erase clears block and write locks
// - locks set from both paths, freely combined
// - pending interrupt request aborts self-programming
// - only mask bits stop an abort, not disable
// - self-programming resumes after re-entry
// - no self-programming on subsystem clock
// - oscillator forced on during self-programming
// - boot clusters are two 4 KB regions
// - swap flag remaps cluster 1 at reset
package fsb_pkg;
   // ****************************************************************
   // register bus
   // ****************************************************************
   localparam int          REG_AW        = 3;
   localparam int          REG_DW        = 16;
   localparam logic [2:0]  REG_CTRL      = 3'h0;
   localparam logic [2:0]  REG_CMD       = 3'h1;
   localparam logic [2:0]  REG_ADDR      = 3'h2;
   localparam logic [2:0]  REG_DATA      = 3'h3;
   localparam logic [2:0]  REG_SECSET    = 3'h4;
   localparam logic [2:0]  REG_STATUS    = 3'h5;
   localparam logic [2:0]  REG_NVSTAT    = 3'h6;
   localparam int          CTRL_ENTER    = 0;
   localparam int          CTRL_EXIT     = 1;
   localparam int          CTRL_RESUME   = 2;
   localparam int          ST_MODE_LSB   = 0;
   localparam int          ST_BUSY       = 4;
   localparam int          ST_DONE       = 5;
   localparam int          ST_ERR        = 6;
   localparam int          ST_ABORT      = 7;
   localparam int          ST_ACT_LSB    = 8;
   localparam int          ST_SWAP       = 12;
   // ****************************************************************
   // security bits
   // ****************************************************************
   localparam int          SEC_W         = 5;
   localparam int          SEC_CE        = 0;
   localparam int          SEC_BE        = 1;
   localparam int          SEC_WR        = 2;
   localparam int          SEC_BC0       = 3;
   localparam int          SEC_SWAP      = 4;
   localparam int          SEC_SWAP_CLR  = 5;
   localparam logic [4:0]  SEC_SHIPPED   = 5'h00;
   // ****************************************************************
   // flash addresses and commands
   // ****************************************************************
   localparam int          FA_W          = 16;
   localparam logic [15:0] BC1_BASE      = 16'h1000;
   localparam logic [15:0] BC_END        = 16'h2000;
   localparam int          IRQ_BYTES     = 4;
   localparam int          BOOT_WAIT     = 3;
   typedef enum logic [1:0] {
      OP_CHIP_ERASE  = 2'h0,
      OP_BLOCK_ERASE = 2'h1,
      OP_WRITE       = 2'h2,
      OP_SEC_SET     = 2'h3
   } fsb_op_t;
   typedef enum logic [3:0] {
      MD_BOOT   = 4'b0001,
      MD_NORMAL = 4'b0010,
      MD_PROG   = 4'b0100,
      MD_SELF   = 4'b1000
   } fsb_mode_t;
   typedef enum logic [1:0] {
      EX_IDLE = 2'b01,
      EX_BUSY = 2'b10
   } fsb_exec_t;
endpackage : fsb_pkg

// *** fsb_nv_if.sv ***
// carrier between the gating logic and the non-volatile security store
`timescale 1ns/1ps
`default_nettype none
interface fsb_nv_if;
   import fsb_pkg::*;
   logic              set_req;
   logic [SEC_W-1:0]  set_bits;
   logic              clr_req;
   logic              swap_clr;
   logic [SEC_W-1:0]  stored;
   modport gate  (output set_req, output set_bits, output clr_req, output swap_clr,
                  input stored);
   modport store (input set_req, input set_bits, input clr_req, input swap_clr,
                  output stored);
endinterface : fsb_nv_if
`default_nettype wire

// *** fsb_nvstore.sv ***
// non-volatile security and boot swap bits
`timescale 1ns/1ps
`default_nettype none
module fsb_nvstore
   import fsb_pkg::*;
(
   input  wire logic  i_clk,
   input  wire logic  i_npor,
   fsb_nv_if.store    nv
);
   logic [SEC_W-1:0] bits_q;

   // ****************************************************************
   // storage
   // ****************************************************************
   // only power-on restores the shipped state
   always_ff @(posedge i_clk or negedge i_npor)
   begin
      if (!i_npor)
      begin
         bits_q <= SEC_SHIPPED;
      end
      else
      begin
         // locks accumulate from either path; programmer chip erase clears block and write locks
         if (nv.clr_req && !bits_q[SEC_CE])
         begin
            // only block and write locks clear; boot-cluster lock stays
            bits_q[SEC_BE] <= nv.set_req & nv.set_bits[SEC_BE];
            bits_q[SEC_WR] <= nv.set_req & nv.set_bits[SEC_WR];
         end
         else if (nv.set_req)
         begin
            bits_q[SEC_BE] <= bits_q[SEC_BE] | nv.set_bits[SEC_BE];
            bits_q[SEC_WR] <= bits_q[SEC_WR] | nv.set_bits[SEC_WR];
         end
         if (nv.set_req)
         begin
            bits_q[SEC_CE]  <= bits_q[SEC_CE] | nv.set_bits[SEC_CE];
            bits_q[SEC_BC0] <= bits_q[SEC_BC0] | nv.set_bits[SEC_BC0];
         end
         // set wins over clear on the swap flag
         if (nv.set_req && nv.set_bits[SEC_SWAP])
         begin
            bits_q[SEC_SWAP] <= 1'b1;
         end
         else if (nv.swap_clr)
         begin
            bits_q[SEC_SWAP] <= 1'b0;
         end
      end
   end

   assign nv.stored = bits_q;
endmodule : fsb_nvstore
`default_nettype wire

// *** fsb_gate_monitor.sv ***
// checker for the flash security gate ports
`timescale 1ns/1ps
`default_nettype none
module fsb_gate_monitor
   import fsb_pkg::*;
(
   input wire logic            i_clk,
   input wire logic            i_nrst,
   input wire logic            i_pg_valid,
   input wire logic            o_pg_nak,
   input wire logic            o_fl_start,
   input wire logic            o_fl_abort,
   input wire logic            i_fl_done,
   input wire logic [7:0]      i_irq_request_flags_0_low,
   input wire logic [7:0]      i_irq_request_flags_0_high,
   input wire logic [7:0]      i_irq_request_flags_1_low,
   input wire logic [7:0]      i_irq_request_flags_1_high,
   input wire logic [7:0]      i_irq_mask_flags_0_low,
   input wire logic [7:0]      i_irq_mask_flags_0_high,
   input wire logic [7:0]      i_irq_mask_flags_1_low,
   input wire logic [7:0]      i_irq_mask_flags_1_high,
   input wire logic            i_cpu_on_subclk,
   input wire logic            i_internal_osc_stop_flag,
   input wire logic            i_cpu_stop,
   input wire logic            o_hsosc_run,
   input wire logic            o_boot_swap,
   input wire logic [FA_W-1:0] i_map_addr,
   input wire logic [FA_W-1:0] o_map_addr,
   input wire logic [3:0]      o_mode
);
   logic        pend;
   logic        busy_q;
   // only mask bits keep a request from aborting
   assign pend = |({i_irq_request_flags_1_high, i_irq_request_flags_1_low,
                    i_irq_request_flags_0_high, i_irq_request_flags_0_low}
                   & ~{i_irq_mask_flags_1_high, i_irq_mask_flags_1_low,
                       i_irq_mask_flags_0_high, i_irq_mask_flags_0_low});
   // busy from the cycle after start
   always_ff @(posedge i_clk or negedge i_nrst)
      if (!i_nrst)
         busy_q <= 1'b0;
      else if (o_fl_abort || i_fl_done)
         busy_q <= 1'b0;
      else if (o_fl_start && o_mode == MD_SELF)
         busy_q <= 1'b1;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   nak_cause_a: assert property (o_pg_nak |-> $past(i_pg_valid) && !o_fl_start)
      else $error("bad nak");
   abort_due_a: assert property (busy_q && pend && !i_fl_done && !o_fl_abort
      && o_mode == MD_SELF |=> o_fl_abort) else $error("no abort");
   abort_cause_a: assert property (o_fl_abort |-> $past(pend))
      else $error("bad abort");
   osc_forced_a: assert property (o_mode == MD_SELF |-> o_hsosc_run)
      else $error("osc off in self");
   osc_free_a: assert property (!$past(i_internal_osc_stop_flag) && !$past(i_cpu_stop)
      |-> o_hsosc_run) else $error("osc off");
   osc_stops_a: assert property (o_mode == MD_NORMAL
      && $past(i_internal_osc_stop_flag) |-> !o_hsosc_run) else $error("osc on");
   swap_map_a: assert property (o_boot_swap && $past(i_map_addr) < BC_END
      |-> o_map_addr == ($past(i_map_addr) ^ BC1_BASE)) else $error("bad swap map");
   plain_map_a: assert property (!o_boot_swap
      || $past(i_map_addr) >= BC_END |-> o_map_addr == $past(i_map_addr))
      else $error("bad plain map");
   subclk_excl_a: assert property ($past(i_cpu_on_subclk) && $past(i_cpu_on_subclk, 2)
      |-> o_mode != MD_SELF) else $error("self on subclk");
   cover property (o_fl_abort);
   cover property (o_pg_nak);
   cover property (o_fl_start && o_mode == MD_SELF);
endmodule : fsb_gate_monitor
bind fsb_gate fsb_gate_monitor u_mon (.*);
`default_nettype wire

// *** fsb_flash_model.sv ***
// flash array stand-in with a set delay
`timescale 1ns/1ps
`default_nettype none
module fsb_flash_model (
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_start,
   input  wire logic       i_abort,
   input  wire logic [7:0] i_delay,
   output logic            o_done
);
   logic [7:0] cnt_q;
   // an abort stops the count and masks done from the next cycle; a done already due in the abort's own cycle still shows
   always_ff @(posedge i_clk or negedge i_nrst)
      if (!i_nrst)
      begin
         cnt_q  <= 8'h00;
         o_done <= 1'b0;
      end
      else
      begin
         o_done <= cnt_q == 8'h01 && !i_abort;
         if (i_start)
            cnt_q <= i_delay;
         else if (i_abort)
            cnt_q <= 8'h00;
         else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
      end
endmodule : fsb_flash_model
`default_nettype wire

// *** fsb_gate_tb.sv ***
// testbench for the flash security gate
`timescale 1ns/1ps
`default_nettype none
module fsb_gate_tb;
   import fsb_pkg::*;
   logic        i_clk = 0, i_nrst = 0, i_npor = 0, i_flash_mode_select_pin = 1;
   logic        i_wr = 0, i_rd = 0, i_pg_valid = 0, i_fl_done, i_cpu_on_subclk = 0;
   logic        i_internal_osc_stop_flag = 0, i_cpu_stop = 0;
   logic        o_pg_ack, o_pg_nak, o_fl_start, o_fl_abort, o_hsosc_run, o_boot_swap;
   logic [2:0]  i_addr = 0;
   logic [1:0]  i_pg_cmd = 0, o_fl_op;
   logic [7:0]  i_pg_data = 0, o_fl_data, dly = 5;
   logic [15:0] i_wdata = 0, i_pg_addr = 0, i_map_addr = 0, o_rdata, o_fl_addr, o_map_addr;
   logic [31:0] irq = 0, msk = 0;
   logic [3:0]  o_mode;
   int          miscompares = 0, num_checks = 0, cyc = 0;
   fsb_gate uut (.*, .i_irq_request_flags_0_low(irq[7:0]), .i_irq_request_flags_0_high(irq[15:8]),
      .i_irq_request_flags_1_low(irq[23:16]), .i_irq_request_flags_1_high(irq[31:24]),
      .i_irq_mask_flags_0_low(msk[7:0]), .i_irq_mask_flags_0_high(msk[15:8]),
      .i_irq_mask_flags_1_low(msk[23:16]), .i_irq_mask_flags_1_high(msk[31:24]));
   fsb_flash_model u_fl (.i_clk(i_clk), .i_nrst(i_npor), .i_start(o_fl_start),
      .i_abort(o_fl_abort), .i_delay(dly), .o_done(i_fl_done));
   always #20 i_clk = ~i_clk;
   // ceiling far above the run's length
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wreg(input logic [2:0] a, logic [15:0] d);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr    <= 1'b0;
      @(posedge i_clk);
   endtask : wreg
   task automatic rreg(input logic [2:0] a, logic [15:0] e);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1 chk(o_rdata, e);
      @(posedge i_clk);
   endtask : rreg
   task automatic pg(input logic [1:0] c, logic [15:0] a, logic [7:0] d, logic e);
      int n = 0;
      i_pg_cmd   <= c;
      i_pg_addr  <= a;
      i_pg_data  <= d;
      i_pg_valid <= 1'b1;
      @(posedge i_clk);
      i_pg_valid <= 1'b0;
      #1;
      while (o_pg_ack !== 1'b1 && o_pg_nak !== 1'b1 && n < 60)
      begin
         @(posedge i_clk);
         #1 n++;
      end
      chk({14'h0, o_pg_nak, o_pg_ack}, {14'h0, !e, e});
      @(posedge i_clk);
   endtask : pg
   task automatic rst(input logic p);
      i_nrst <= 1'b0;
      i_flash_mode_select_pin <= p;
      repeat (4) @(posedge i_clk);
      i_nrst <= 1'b1;
      i_npor <= 1'b1;
      repeat (6) @(posedge i_clk);
   endtask : rst
   initial
   begin
      rst(1'b1);
      chk({12'h0, o_mode}, {12'h0, MD_PROG});
      pg(OP_WRITE, 16'h0000, 8'h5a, 1);
      pg(OP_BLOCK_ERASE, 16'h0000, 8'h00, 1);
      pg(OP_CHIP_ERASE, 16'h0000, 8'h00, 1);
      pg(OP_SEC_SET, 16'h0000, 8'h04, 1);
      rreg(REG_NVSTAT, 16'h0004);
      pg(OP_WRITE, 16'h2000, 8'h01, 1);
      rst(1'b1);
      pg(OP_WRITE, 16'h2000, 8'h01, 0);
      pg(OP_BLOCK_ERASE, 16'h3000, 8'h00, 0);
      pg(OP_CHIP_ERASE, 16'h0000, 8'h00, 1);
      rreg(REG_NVSTAT, 16'h0000);
      pg(OP_SEC_SET, 16'h0000, 8'h02, 1);
      rst(1'b1);
      pg(OP_BLOCK_ERASE, 16'h3000, 8'h00, 0);
      pg(OP_WRITE, 16'h3000, 8'h00, 1);
      rst(1'b0);
      i_flash_mode_select_pin <= 1'b1;
      i_cpu_on_subclk <= 1'b1;
      repeat (3) @(posedge i_clk);
      wreg(REG_CTRL, 16'h0001);
      rreg(REG_STATUS, 16'h0202);
      i_cpu_on_subclk <= 1'b0;
      wreg(REG_CTRL, 16'h0001);
      rreg(REG_STATUS, 16'h0208);
      i_internal_osc_stop_flag <= 1'b1;
      i_cpu_stop <= 1'b1;
      repeat (2) @(posedge i_clk);
      chk({15'h0, o_hsosc_run}, 16'h0001);
      wreg(REG_ADDR, 16'h3000);
      wreg(REG_CMD, 16'h0001);
      repeat (12) @(posedge i_clk);
      rreg(REG_STATUS, 16'h0228);
      irq <= 32'h0000_0100;
      msk <= 32'hffff_ffff;
      dly <= 8'h28;
      wreg(REG_CMD, 16'h0002);
      rreg(REG_STATUS, 16'h0218);
      msk <= 32'h0000_0000;
      repeat (3) @(posedge i_clk);
      rreg(REG_STATUS, 16'h0288);
      wreg(REG_CTRL, 16'h0002);
      irq <= 32'h0000_0000;
      wreg(REG_CTRL, 16'h0001);
      dly <= 8'h05;
      wreg(REG_CTRL, 16'h0004);
      repeat (12) @(posedge i_clk);
      rreg(REG_STATUS, 16'h0228);
      wreg(REG_SECSET, 16'h0018);
      wreg(REG_CMD, 16'h0003);
      repeat (3) @(posedge i_clk);
      rreg(REG_NVSTAT, 16'h001a);
      wreg(REG_CTRL, 16'h0002);
      rst(1'b1);
      chk({15'h0, o_boot_swap}, 16'h0001);
      i_map_addr <= 16'h0123;
      repeat (2) @(posedge i_clk);
      #1 chk(o_map_addr, 16'h1123);
      @(posedge i_clk);
      i_map_addr <= 16'h0000;
      pg(OP_CHIP_ERASE, 16'h0000, 8'h00, 0);
      pg(OP_WRITE, 16'h0fff, 8'h00, 0);
      pg(OP_WRITE, 16'h1000, 8'h00, 1);
      pg(OP_SEC_SET, 16'h0000, 8'h01, 1);
      rst(1'b1);
      pg(OP_WRITE, 16'h2000, 8'h00, 1);
      pg(OP_BLOCK_ERASE, 16'h2000, 8'h00, 0);
      rreg(REG_NVSTAT, 16'h001b);
      tally_and_finish();
   end
endmodule : fsb_gate_tb
`default_nettype wire
